/* logic/erxbc_status.sv */
// receive buffer count and ethernet status register block with axi4-lite slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] each received packet adds its descriptor count to the buffer count in status bits 23:16.
// [R2] software writes the decrement control bit once per descriptor it has consumed.
// [R3] an increment at count 0xff leaves the count at 0xff.
// [R4] a decrement at count zero is ignored.
// [R5] an increment and a decrement in the same cycle leave the count unchanged.
// [R6] with flow control on, receive halts while the count is 0xff until software lowers it.
// [R7] with flow control off, receive keeps running and the count saturates at 0xff.
// [R8] packet pending is high while the count is non-zero and interrupts only when enabled.
// [R9] any write to the receive start address register clears the count.
// [R10] turning the module off leaves the count intact and still decrementable.
// [R11] module active bit 7 is high while on or while finishing a transaction, low when idle.
// [R12] transmit active bit 6 is high during transmission and cleared when the module is off.
// [R13] transmit active falling does not imply a transmit done event.
// [R14] packet pending clears only by reset, decrements or a receive start address write; direct writes do nothing.
// [R15] receive active bit 5 is high while a packet is received, cleared when the module is off.
module erxbc_status
    import erxbc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // receive engine side
    input wire logic rx_pkt_done,
    input wire logic [7:0] rx_pkt_desc_cnt,
    input wire logic rx_in_packet,
    output logic rx_halt,
    // transmit and engine activity
    input wire logic tx_in_packet,
    input wire logic engine_draining,
    // control outputs
    output logic module_on,
    output logic [31:0] rx_start_address,
    // interrupt
    output logic irq
);

    //////////////////////////////////////////////////////////////////////////
    // axi4-lite write path: address and data latched in either order

    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
    wire [7:0] wr_word = {aw_addr_q[7:2], 2'b00};

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    wire sel_w_ctrl = wr_fire && (wr_word == ERXBC_OFS_CTRL);
    wire sel_w_start = wr_fire && (wr_word == ERXBC_OFS_RXSTART);
    wire sel_w_stat = wr_fire && (wr_word == ERXBC_OFS_STATUS);
    wire sel_w_irqs = wr_fire && (wr_word == ERXBC_OFS_IRQ_STAT);
    wire sel_w_en = wr_fire && (wr_word == ERXBC_OFS_IRQ_EN);
    wire sel_w_clr = wr_fire && (wr_word == ERXBC_OFS_IRQ_CLR);
    // status and irq status accept writes but ignore them
    wire wr_mapped = sel_w_ctrl | sel_w_start | sel_w_stat | sel_w_irqs | sel_w_en | sel_w_clr;

    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (aw_take) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (w_take) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_mapped ? ERXBC_RESP_OKAY : ERXBC_RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // control register: on, auto flow control, self-clearing decrement

    logic on_q, on_d;
    logic afc_q, afc_d;
    logic [31:0] start_q, start_d;
    logic [1:0] irq_en_q, irq_en_d;

    // decrement is a strobe; it never stays set in the register
    wire sw_dec = sel_w_ctrl && w_strb_q[0] && w_data_q[ERXBC_CTRL_DEC_BIT]; // R2

    always_comb begin
        on_d = on_q;
        afc_d = afc_q;
        start_d = start_q;
        irq_en_d = irq_en_q;
        if (sel_w_ctrl && w_strb_q[1]) begin
            on_d = w_data_q[ERXBC_CTRL_ON_BIT];
        end
        if (sel_w_ctrl && w_strb_q[0]) begin
            afc_d = w_data_q[ERXBC_CTRL_AFC_BIT];
        end
        if (sel_w_start) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_q[b]) begin
                    start_d[b*8 +: 8] = w_data_q[b*8 +: 8];
                end
            end
        end
        if (sel_w_en && w_strb_q[0]) begin
            irq_en_d = w_data_q[1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // buffer count

    logic [7:0] cnt_q, cnt_d;
    wire hw_inc = rx_pkt_done && (rx_pkt_desc_cnt != 8'h00);
    wire [8:0] cnt_sum = {1'b0, cnt_q} + {1'b0, rx_pkt_desc_cnt};

    // count is not touched by the on bit, so it survives turn-off
    always_comb begin // R10
        cnt_d = cnt_q;
        if (sel_w_start) begin
            cnt_d = ERXBC_CNT_RST; // R9
        end else if (hw_inc && sw_dec) begin
            cnt_d = cnt_q; // R5
        end else if (hw_inc) begin
            cnt_d = cnt_sum[8] ? ERXBC_CNT_MAX : cnt_sum[7:0]; // R1 R3 R7
        end else if (sw_dec && (cnt_q != ERXBC_CNT_RST)) begin
            cnt_d = cnt_q - 8'h01; // R4
        end
    end

    wire pkt_pending = (cnt_q != ERXBC_CNT_RST); // R8 R14
    wire cnt_full = (cnt_q == ERXBC_CNT_MAX);
    // only halts with flow control on; otherwise dma runs on saturated
    assign rx_halt = afc_q && cnt_full; // R6 R7

    //////////////////////////////////////////////////////////////////////////
    // activity status: synchronous to clk, no pins here so no synchroniser

    wire mod_active = on_q || engine_draining; // R11
    wire tx_active = on_q && tx_in_packet; // R12 R13
    wire rx_active = on_q && rx_in_packet; // R15

    //////////////////////////////////////////////////////////////////////////
    // interrupt: sticky status, enable, write-one clear

    logic [1:0] irq_stat_q, irq_stat_d;
    logic pend_prev_q;
    wire [1:0] irq_evt = {hw_inc && (cnt_d == ERXBC_CNT_MAX) && !cnt_full,
                          pkt_pending && !pend_prev_q};
    wire [1:0] irq_clr = (sel_w_clr && w_strb_q[0]) ? w_data_q[1:0] : 2'b00;

    // set beats clear in the same cycle
    assign irq_stat_d = irq_evt | (irq_stat_q & ~irq_clr);
    assign irq = |(irq_stat_q & irq_en_q); // R8

    //////////////////////////////////////////////////////////////////////////
    // axi4-lite read path

    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    wire [7:0] rd_word = {s_axi_araddr[7:2], 2'b00};
    wire ar_take = s_axi_arvalid && s_axi_arready;

    wire [31:0] status_word = {8'h00, cnt_q, 8'h00, mod_active, tx_active, rx_active, 5'h00};
    wire [31:0] ctrl_word = {16'h0000, on_q, 13'h0000, afc_q, 1'b0};

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (ar_take) begin
            rvalid_d = 1'b1;
            rresp_d = ERXBC_RESP_OKAY;
            unique case (rd_word)
                ERXBC_OFS_STATUS: rdata_d = status_word;
                ERXBC_OFS_CTRL: rdata_d = ctrl_word;
                ERXBC_OFS_RXSTART: rdata_d = start_q;
                ERXBC_OFS_IRQ_STAT: rdata_d = {30'h0, irq_stat_q};
                ERXBC_OFS_IRQ_EN: rdata_d = {30'h0, irq_en_q};
                ERXBC_OFS_IRQ_CLR: rdata_d = 32'h0000_0000;
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = ERXBC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    assign module_on = on_q;
    assign rx_start_address = start_q;

    //////////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else begin
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            w_held_q <= w_held_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= ERXBC_RESP_OKAY;
        end else begin
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rresp_q <= ERXBC_RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            on_q <= 1'b0;
        end else begin
            on_q <= on_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            afc_q <= 1'b0;
        end else begin
            afc_q <= afc_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_q <= ERXBC_RXSTART_RST;
        end else begin
            start_q <= start_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_en_q <= 2'b00;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= ERXBC_CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat_q <= 2'b00;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_prev_q <= 1'b0;
        end else begin
            pend_prev_q <= pkt_pending;
        end
    end

endmodule

/* logic/erxbc_pkg.sv */
// shared constants for the receive buffer count status block
package erxbc_pkg;
    // register byte offsets
    localparam logic [7:0] ERXBC_OFS_STATUS = 8'h00;
    localparam logic [7:0] ERXBC_OFS_CTRL = 8'h04;
    localparam logic [7:0] ERXBC_OFS_RXSTART = 8'h08;
    localparam logic [7:0] ERXBC_OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ERXBC_OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] ERXBC_OFS_IRQ_CLR = 8'h14;
    // status field positions
    localparam int ERXBC_CNT_LSB = 16;
    localparam int ERXBC_CNT_MSB = 23;
    localparam int ERXBC_MOD_BIT = 7;
    localparam int ERXBC_TX_BIT = 6;
    localparam int ERXBC_RX_BIT = 5;
    // control field positions
    localparam int ERXBC_CTRL_DEC_BIT = 0;
    localparam int ERXBC_CTRL_AFC_BIT = 1;
    localparam int ERXBC_CTRL_ON_BIT = 15;
    // interrupt status / enable / clear positions
    localparam int ERXBC_IRQ_PEND_BIT = 0;
    localparam int ERXBC_IRQ_SAT_BIT = 1;
    // count limits and reset values
    localparam logic [7:0] ERXBC_CNT_MAX = 8'hff;
    localparam logic [7:0] ERXBC_CNT_RST = 8'h00;
    localparam logic [31:0] ERXBC_RXSTART_RST = 32'h0000_0000;
    localparam logic [1:0] ERXBC_RESP_OKAY = 2'b00;
    localparam logic [1:0] ERXBC_RESP_SLVERR = 2'b10;
endpackage

/* testbench/erxbc_chk.sv */
// port-level checker for the buffer count status block
`timescale 1ns/1ps
module erxbc_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // receive and interrupt
    input wire logic rx_pkt_done,
    input wire logic rx_halt,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // only a software write can lower the count out of halt
    a_halt_until_dec: assert property ($fell(rx_halt) |-> $rose(s_axi_bvalid))
        else $error("halt released without a write");
    a_halt_by_event: assert property ($rose(rx_halt) |->
        $past(rx_pkt_done) || $rose(s_axi_bvalid)) else $error("halt rose without cause");
    a_irq_rise_cause: assert property ($rose(irq) |->
        $past(rx_pkt_done) || $past(rx_pkt_done, 2) || $rose(s_axi_bvalid))
        else $error("irq rose without cause");
    a_irq_fall_write: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("irq fell without a write");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped early");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while response pending");
    c_halt_rise: cover property ($rose(rx_halt));
    c_halt_fall: cover property ($fell(rx_halt));
    c_irq_rise: cover property ($rose(irq));
endmodule
bind erxbc_status erxbc_chk u_chk (.*);

/* testbench/erxbc_status_bench.sv */
// self-checking bench for the buffer count status block
`timescale 1ns/1ps
module erxbc_status_bench;
    import erxbc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rx_pkt_desc_cnt = '0, cnt;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rx_start_address, rd, ctl, sa;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_pkt_done = 1'b0;
    logic rx_in_packet = 1'b0, tx_in_packet = 1'b0, engine_draining = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic rx_halt, module_on, irq;
    logic [2:0] act;
    int fail_count = 0, n_tests = 0, seed = 51, i;
    erxbc_status dut (.*);
    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] sat(input logic [7:0] c, d);
        return (9'(c) + 9'(d) > 9'h0ff) ? 8'hff : c + d;
    endfunction
    task automatic check(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // inc puts a packet done on the very edge the write takes effect
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic inc = 1'b0);
        logic ta, tw;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        rx_pkt_desc_cnt <= 8'h01;
        do begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!((ta || !s_axi_awvalid) && (tw || !s_axi_wvalid)));
        rx_pkt_done <= inc;
        @(posedge clk);
        rx_pkt_done <= 1'b0;
        do @(negedge clk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pkt(input logic [7:0] d);
        rx_pkt_done <= 1'b1;
        rx_pkt_desc_cnt <= d;
        @(posedge clk);
        rx_pkt_done <= 1'b0;
        cnt = sat(cnt, d);
        @(posedge clk);
    endtask
    task automatic dec;
        wr(ERXBC_OFS_CTRL, ctl | 32'h1);
        if (cnt != 8'h00) cnt--;
    endtask
    task automatic cc;
        rdr(ERXBC_OFS_STATUS);
        check(rd[23:16], cnt);
    endtask
    task automatic activity(input logic on);
        for (i = 0; i < 4; i++) begin
            act = 3'($random(seed));
            {tx_in_packet, rx_in_packet, engine_draining} <= act;
            @(posedge clk);
            rdr(ERXBC_OFS_STATUS);
            check(rd[7:5], on ? {1'b1, act[2:1]} : {act[0], 2'b00});
        end
    endtask
    initial begin
        cnt = 8'h00;
        ctl = 32'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cc;
        dec;
        cc;
        wr(ERXBC_OFS_IRQ_EN, 32'h1);
        for (int k = 0; k < 6; k++) begin
            pkt(8'($random(seed)) & 8'h0f);
            cc;
        end
        check(irq, cnt != 8'h00);
        wr(ERXBC_OFS_IRQ_EN, 32'h0);
        check(irq, 1'b0);
        wr(ERXBC_OFS_IRQ_EN, 32'h1);
        wr(ERXBC_OFS_STATUS, 32'h0);
        check(resp, ERXBC_RESP_OKAY);
        cc;
        repeat (2) dec;
        cc;
        repeat (5) pkt(8'h40);
        cc;
        check(rx_halt, 1'b0);
        rdr(ERXBC_OFS_IRQ_STAT);
        check(rd, 32'h3);
        ctl = 32'h2;
        wr(ERXBC_OFS_CTRL, ctl);
        check(rx_halt, 1'b1);
        pkt(8'h05);
        cc;
        dec;
        check(rx_halt, 1'b0);
        wr(ERXBC_OFS_CTRL, ctl | 32'h1, 1'b1);
        cc;
        ctl = 32'h8000;
        wr(ERXBC_OFS_CTRL, ctl);
        check(module_on, 1'b1);
        activity(1'b1);
        ctl = 32'h0;
        wr(ERXBC_OFS_CTRL, ctl);
        check(module_on, 1'b0);
        activity(1'b0);
        cc;
        dec;
        cc;
        sa = 32'($random(seed));
        wr(ERXBC_OFS_RXSTART, sa);
        check(rx_start_address, sa);
        cnt = 8'h00;
        cc;
        wr(ERXBC_OFS_IRQ_CLR, 32'h1);
        check(irq, 1'b0);
        rdr(8'h18);
        check(resp, ERXBC_RESP_SLVERR);
        check(rd, 32'h0);
        wr(8'h18, 32'h0);
        check(resp, ERXBC_RESP_SLVERR);
        // mid-run reset must drop the count and the sticky status
        pkt(8'h03);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cnt = 8'h00;
        cc;
        rdr(ERXBC_OFS_IRQ_STAT);
        check(rd, 32'h0);
        print_verdict;
    end
    initial begin
        #400000;
        fail_count++;
        print_verdict;
    end
endmodule
